/* hdl/pld_top.sv */
// Line decode/encode of a 10/100 PHY: 100M receive decode, 10M transmit and receive.
// Assumes DSP bit stream and MAC nibbles on mclk_i; analog pins are synchronised here.
`timescale 1ns/10ps
`default_nettype none
`include "pld_defines.svh"
module pld_top import pld_pkg::*; #(
    parameter logic [15:0] IDLE_TMO  = 16'(`PLD_IDLE_WIN_US * `PLD_CLK_MHZ),
    parameter logic [23:0] JAB_LIM   = 24'(`PLD_JAB_US * `PLD_CLK_MHZ),
    parameter logic [23:0] NLP_PER   = 24'(`PLD_NLP_US * `PLD_CLK_MHZ),
    parameter logic [24:0] LINK_LOSS = 25'(`PLD_LINK_LOSS_US * `PLD_CLK_MHZ)
) (
    input  wire logic       mclk_i,
    input  wire logic       rst_b_i,
    input  wire logic       descr_bypass_i,
    input  wire logic [5:0] adc_code_i,
    input  wire logic       adc_strb_i,
    output logic      [5:0] dsp_sample_o,
    output logic            dsp_sample_vld_o,
    input  wire logic       rx100_bit_i,
    input  wire logic       rx100_bit_vld_i,
    output logic      [3:0] rxd_o,
    output logic            rx_nib_vld_o,
    output logic            rx_dv_o,
    output logic            crs_o,
    output logic            rx_er_o,
    output logic            descr_locked_o,
    output logic            tx_clk_o,
    input  wire logic [3:0] txd_i,
    input  wire logic       tx_en_i,
    output logic            tp_tx_o,
    output logic            tp_tx_act_o,
    output logic            jabber_o,
    input  wire logic       rx10_line_i,
    input  wire logic       rx10_squelch_i,
    output logic      [3:0] rx10_rxd_o,
    output logic            rx10_nib_vld_o,
    output logic            rx10_dv_o,
    output logic            rx10_code_err_o,
    output logic            polarity_reversed_flag_o,
    output logic            link10_ok_o
);
    localparam logic [23:0] NLP_W = 24'((`PLD_NLP_W_NS * `PLD_CLK_MHZ + 999) / 1000);

    pld_state_t st_reg;
    pld_state_t st_next;

    function automatic logic [4:0] dec5(input logic [4:0] c);
        case (c)
            5'h1E: dec5 = 5'h10;
            5'h09: dec5 = 5'h11;
            5'h14: dec5 = 5'h12;
            5'h15: dec5 = 5'h13;
            5'h0A: dec5 = 5'h14;
            5'h0B: dec5 = 5'h15;
            5'h0E: dec5 = 5'h16;
            5'h0F: dec5 = 5'h17;
            5'h12: dec5 = 5'h18;
            5'h13: dec5 = 5'h19;
            5'h16: dec5 = 5'h1A;
            5'h17: dec5 = 5'h1B;
            5'h1A: dec5 = 5'h1C;
            5'h1B: dec5 = 5'h1D;
            5'h1C: dec5 = 5'h1E;
            5'h1D: dec5 = 5'h1F;
            default: dec5 = 5'h00;
        endcase
    endfunction

    always_comb begin
        logic       d;
        logic       kb;
        logic       go;
        logic [4:0] cg;
        logic [4:0] dn;
        logic       lvl;
        logic       b;
        logic       m;
        d  = 1'b0;
        kb = 1'b0;
        go = 1'b0;
        cg = 5'h00;
        dn = 5'h00;
        b  = 1'b0;
        m  = 1'b0;
        lvl = 1'b0;
        st_next = st_reg;
        st_next.rxv   = 1'b0;
        st_next.er    = 1'b0;
        st_next.rxv10 = 1'b0;
        st_next.cerr  = 1'b0;
        st_next.a1    = {adc_strb_i, adc_code_i};
        st_next.a2    = st_reg.a1;
        st_next.smp_v = st_reg.a2[6];
        if (st_reg.a2[6]) begin
            st_next.smp = st_reg.a2[5:0];
        end
        if (st_reg.kp) begin
            st_next.kp  = 1'b0;
            st_next.rxd = `PLD_SSD_NIB;
            st_next.rxv = 1'b1;
        end
        if (st_reg.lock && !descr_bypass_i) begin
            st_next.tmo = st_reg.tmo + 16'h0001;
        end
        if (rx100_bit_vld_i) begin
            if (descr_bypass_i) begin
                d  = rx100_bit_i;
                go = 1'b1;
            end else if (!st_reg.lock) begin
                st_next.lfsr = {st_reg.lfsr[9:0], ~rx100_bit_i};
                st_next.scnt = st_reg.scnt + 4'h1;
                st_next.lock = (st_reg.scnt == `PLD_SYNC_BITS);
            end else begin
                kb = st_reg.lfsr[10] ^ st_reg.lfsr[8];
                st_next.lfsr = {st_reg.lfsr[9:0], kb};
                d  = rx100_bit_i ^ kb;
                go = 1'b1;
            end
            if (go) begin
                st_next.ones = d ? ((st_reg.ones == `PLD_IDLE_ONES) ? st_reg.ones
                                    : st_reg.ones + 4'h1) : 4'h0;
                if (st_next.ones == `PLD_IDLE_ONES) begin
                    st_next.tmo = 16'h0000;
                end
                st_next.sh = {st_reg.sh[8:0], d};
                cg = st_next.sh[4:0];
                dn = dec5(cg);
                st_next.bc = (st_reg.bc == 3'h4) ? 3'h0 : st_reg.bc + 3'h1;
                case (st_reg.r1)
                    R1_HUNT: begin
                        if (st_next.sh == {`PLD_CG_J, `PLD_CG_K}) begin
                            st_next.r1  = R1_DATA;
                            st_next.bc  = 3'h0;
                            st_next.idl = 1'b0;
                            st_next.rxd = `PLD_SSD_NIB;
                            st_next.rxv = 1'b1;
                            st_next.kp  = 1'b1;
                            st_next.dv  = 1'b1;
                            st_next.crs = 1'b1;
                        end
                    end
                    R1_TEND: begin
                        if (st_reg.bc == 3'h4) begin
                            if (cg == `PLD_CG_R) begin
                                st_next.r1  = R1_HUNT;
                                st_next.dv  = 1'b0;
                                st_next.crs = 1'b0;
                            end else begin
                                st_next.er = 1'b1;
                                st_next.r1 = R1_DATA;
                            end
                        end
                    end
                    R1_DATA: begin
                        if (st_reg.bc == 3'h4) begin
                            if (cg == `PLD_CG_IDLE) begin
                                st_next.idl = 1'b1;
                                if (st_reg.idl) begin
                                    st_next.r1  = R1_HUNT;
                                    st_next.dv  = 1'b0;
                                    st_next.crs = 1'b0;
                                end
                            end else begin
                                st_next.idl = 1'b0;
                                if (cg == `PLD_CG_T) begin
                                    st_next.r1 = R1_TEND;
                                end else if (dn[4]) begin
                                    st_next.rxd = dn[3:0];
                                    st_next.rxv = 1'b1;
                                end else begin
                                    st_next.er = 1'b1;
                                end
                            end
                        end
                    end
                    default: st_next.r1 = R1_HUNT;
                endcase
            end
        end
        if (st_reg.lock && !descr_bypass_i && st_reg.tmo == IDLE_TMO) begin
            st_next.lock = 1'b0;
            st_next.scnt = 4'h0;
            st_next.tmo  = 16'h0000;
            st_next.r1   = R1_HUNT;
            st_next.dv   = 1'b0;
            st_next.crs  = 1'b0;
            st_next.kp   = 1'b0;
        end

        // Half-bit cells of 10 cycles; 8 cells make one 2.5 MHz nibble period
        st_next.hc  = (st_reg.hc == `PLD_HC_LAST) ? 4'h0 : st_reg.hc + 4'h1;
        st_next.ph  = (st_reg.hc == `PLD_HC_LAST) ? st_reg.ph + 3'h1 : st_reg.ph;
        st_next.tck = ~st_next.ph[2];
        if (!tx_en_i) begin
            st_next.jc  = 24'h000000;
            st_next.jab = 1'b0;
        end else if (st_reg.jc == JAB_LIM) begin
            st_next.jab = 1'b1;
        end else begin
            st_next.jc = st_reg.jc + 24'h000001;
        end
        if (st_reg.hc == 4'h0 && st_reg.ph == 3'h0) begin
            st_next.tact = tx_en_i;
            if (tx_en_i) begin
                st_next.txn = txd_i;
            end
        end
        if (st_next.jab) begin
            st_next.tact = 1'b0;
        end
        if (st_next.tact) begin
            // Manchester, low then high for a one
            b = st_next.txn[st_next.ph[2:1]];
            st_next.line = st_next.ph[0] ? b : ~b;
            st_next.lact = 1'b1;
            st_next.nc   = 24'h000000;
        end else if (!tx_en_i) begin
            st_next.nc   = (st_reg.nc == NLP_PER - 24'h000001) ? 24'h000000
                           : st_reg.nc + 24'h000001;
            st_next.line = (st_next.nc < NLP_W);
            st_next.lact = st_next.line;
        end else begin
            st_next.line = 1'b0;
            st_next.lact = 1'b0;
        end

        // Pins from the analog front end go through two flops first
        st_next.l1 = {rx10_line_i, rx10_squelch_i};
        st_next.l2 = st_reg.l1;
        lvl = st_reg.l2[1];
        st_next.lv = lvl;
        st_next.ec = (st_reg.ec == 6'h3F) ? st_reg.ec : st_reg.ec + 6'h01;
        if (st_reg.lk != LINK_LOSS) begin
            st_next.lk = st_reg.lk + 25'h0000001;
        end else begin
            st_next.lok = 1'b0;
        end
        if (lvl != st_reg.lv) begin
            st_next.ec = 6'h00;
            case (st_reg.r2)
                R2_IDLE: begin
                    if (st_reg.l2[0]) begin
                        st_next.r2  = R2_PRE;
                        st_next.mid = 1'b1;
                        st_next.lb  = lvl ^ st_reg.pol;
                    end else if (!lvl && st_reg.ec >= `PLD_P_MIN && st_reg.ec <= `PLD_P_MAX) begin
                        st_next.lk  = 25'h0000000;
                        st_next.lok = 1'b1;
                    end
                end
                R2_PRE, R2_DATA: begin
                    if (st_reg.ec < `PLD_E_MIN || st_reg.ec > `PLD_E_MAX) begin
                        st_next.cerr = 1'b1;
                        st_next.r2   = R2_IDLE;
                        st_next.dv10 = 1'b0;
                    end else begin
                        m = (st_reg.ec >= `PLD_E_LONG) ? 1'b1 : ~st_reg.mid;
                        st_next.mid = m;
                        st_next.lk  = 25'h0000000;
                        b = lvl ^ st_reg.pol;
                        if (m && st_reg.r2 == R2_PRE) begin
                            st_next.lb = b;
                            if (b == st_reg.lb) begin
                                // 00 ending the preamble means swapped pair
                                st_next.pol  = b ? st_reg.pol : ~st_reg.pol;
                                st_next.r2   = R2_DATA;
                                st_next.dv10 = 1'b1;
                                st_next.nb   = 2'h0;
                            end
                        end else if (m) begin
                            // bits to nibbles, first bit lowest
                            st_next.nib = {b, st_reg.nib[3:1]};
                            st_next.nb  = st_reg.nb + 2'h1;
                            if (st_reg.nb == 2'h3) begin
                                st_next.rxd10 = st_next.nib;
                                st_next.rxv10 = 1'b1;
                            end
                        end
                    end
                end
                default: st_next.r2 = R2_IDLE;
            endcase
        end
        if (st_reg.r2 != R2_IDLE && (!st_reg.l2[0] || st_reg.ec == `PLD_E_GAP)) begin
            st_next.r2   = R2_IDLE;
            st_next.dv10 = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg     <= '0;
            st_reg.r1  <= R1_HUNT;
            st_reg.r2  <= R2_IDLE;
            st_reg.tck <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dsp_sample_o             = st_reg.smp;
    assign dsp_sample_vld_o         = st_reg.smp_v;
    assign rxd_o                    = st_reg.rxd;
    assign rx_nib_vld_o             = st_reg.rxv;
    assign rx_dv_o                  = st_reg.dv;
    assign crs_o                    = st_reg.crs;
    assign rx_er_o                  = st_reg.er;
    assign descr_locked_o           = st_reg.lock;
    assign tx_clk_o                 = st_reg.tck;
    assign tp_tx_o                  = st_reg.line;
    assign tp_tx_act_o              = st_reg.lact;
    assign jabber_o                 = st_reg.jab;
    assign rx10_rxd_o               = st_reg.rxd10;
    assign rx10_nib_vld_o           = st_reg.rxv10;
    assign rx10_dv_o                = st_reg.dv10;
    assign rx10_code_err_o          = st_reg.cerr;
    assign polarity_reversed_flag_o = st_reg.pol;
    assign link10_ok_o              = st_reg.lok;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_pre_nib;
        rx_nib_vld_o && rxd_o == `PLD_SSD_NIB;
    endsequence

    a_ssd_preamble: assert property ($rose(rx_dv_o) |-> s_pre_nib ##1 s_pre_nib)
        else $error("start delimiter did not give two 0101 nibbles");
    a_crs_follows_dv: assert property (crs_o == rx_dv_o)
        else $error("carrier sense and data valid differ");
    a_er_in_frame: assert property (rx_er_o |-> rx_dv_o)
        else $error("receive error outside data valid");
    a_tmo_bound: assert property (st_reg.tmo <= IDLE_TMO)
        else $error("idle window counter overran");
    a_abort_drop: assert property ($fell(descr_locked_o) |-> !rx_dv_o && !crs_o)
        else $error("data valid held over descrambler abort");
    a_latch_tx: assert property ($rose(tx_clk_o) && tx_en_i && st_reg.jc < JAB_LIM - 24'h000001
                                 |=> tp_tx_act_o)
        else $error("nibble not sent after clock rise");
    a_jab_silent: assert property (jabber_o |-> !tp_tx_act_o)
        else $error("line driven during jabber");
    a_jab_clear: assert property (!tx_en_i |=> !jabber_o)
        else $error("jabber not cleared by enable low");
    a_nlp_idle: assert property (tp_tx_act_o && !st_reg.tact |-> !$past(tx_en_i))
        else $error("link pulse sent while enable high");
    a_rx10_frame: assert property (rx10_nib_vld_o |-> rx10_dv_o)
        else $error("10M nibble outside data valid");
endmodule
`default_nettype wire

/* hdl/pld_defines.svh */
// Constants of the line decode/encode block: codes, timing, thresholds.
// Assumes a single 200 MHz clock; times are turned into cycles in the module.
// Summary of operation
// - Each 6-bit line sample from the 64-level quantiser is passed on to the DSP.
// - Descrambler learns its key from idle, then holds it to descramble data.
// - No idle within 40 us aborts reception and restarts key learning.
// - Idle window is shorter than a full 1514-byte frame, so long frames abort.
// - Bypass input passes received bits straight to alignment.
// - Descrambled serial bits are shifted into parallel code-group form.
// - Code-group boundary fixed on start delimiter, held until next frame start.
// - Each 5-bit group decodes to a nibble; start delimiter gives 0101 0101.
// - Start delimiter raises receive data valid; following groups are translated.
// - End delimiter or two idles drop carrier sense and data valid, untranslated.
// - Start delimiter is 11000 then 10001; elsewhere they flag receive error.
// - End delimiter is 01101 then 00111; alone either flags error. Idle 11111.
// - Invalid code-group during data valid raises receive error.
// - Transmit nibble is taken on the rising edge of the 2.5 MHz clock.
// - Nibbles are serialised and Manchester coded on 20 MHz half-bit cells.
// - With transmit enable low, normal link pulses are sent.
// - Manchester coding checked; reversed polarity corrected and flagged.
// - Received 10 Mb/s bits are packed into nibbles at 2.5 MHz.
// - Valid normal link pulses keep the 10 Mb/s link up.
// - Over-long transmit enable stops line transmission after 20 ms.
// - Jabber stays latched until transmit enable drops.
`ifndef PLD_DEFINES_SVH
`define PLD_DEFINES_SVH
`define PLD_CLK_MHZ      200
`define PLD_IDLE_WIN_US  40
`define PLD_JAB_US       20000
`define PLD_NLP_US       16000
`define PLD_NLP_W_NS     100
`define PLD_LINK_LOSS_US 150000
`define PLD_SYNC_BITS    4'hA
`define PLD_IDLE_ONES    4'hA
`define PLD_CG_J         5'h18
`define PLD_CG_K         5'h11
`define PLD_CG_T         5'h0D
`define PLD_CG_R         5'h07
`define PLD_CG_IDLE      5'h1F
`define PLD_SSD_NIB      4'h5
`define PLD_HC_LAST      4'h9
`define PLD_E_MIN        6'h05
`define PLD_E_LONG       6'h0F
`define PLD_E_MAX        6'h19
`define PLD_E_GAP        6'h1E
`define PLD_P_MIN        6'h0A
`define PLD_P_MAX        6'h28
`endif

/* hdl/pld_pkg.sv */
// Types of the line decode/encode block: state enums and the state record.
// Assumes pld_defines.svh for all numeric constants.
package pld_pkg;
    typedef enum logic [2:0] {R1_HUNT = 3'b001, R1_DATA = 3'b010, R1_TEND = 3'b100} pld_r100_t;
    typedef enum logic [2:0] {R2_IDLE = 3'b001, R2_PRE = 3'b010, R2_DATA = 3'b100} pld_r10_t;
    typedef struct packed {
        logic [6:0]  a1;
        logic [6:0]  a2;
        logic [5:0]  smp;
        logic        smp_v;
        logic [10:0] lfsr;
        logic        lock;
        logic [3:0]  scnt;
        logic [3:0]  ones;
        logic [15:0] tmo;
        logic [9:0]  sh;
        logic [2:0]  bc;
        pld_r100_t   r1;
        logic        idl;
        logic        kp;
        logic [3:0]  rxd;
        logic        rxv;
        logic        dv;
        logic        crs;
        logic        er;
        logic [3:0]  hc;
        logic [2:0]  ph;
        logic        tck;
        logic [3:0]  txn;
        logic        tact;
        logic [23:0] jc;
        logic        jab;
        logic [23:0] nc;
        logic        line;
        logic        lact;
        logic [1:0]  l1;
        logic [1:0]  l2;
        logic        lv;
        logic [5:0]  ec;
        pld_r10_t    r2;
        logic        mid;
        logic        lb;
        logic        pol;
        logic [1:0]  nb;
        logic [3:0]  nib;
        logic [3:0]  rxd10;
        logic        rxv10;
        logic        dv10;
        logic        cerr;
        logic [24:0] lk;
        logic        lok;
    } pld_state_t;
endpackage

/* bench/pld_mac_model.sv */
// MAC side of the internal MII: transmit nibbles paced by the 2.5 MHz clock.
// Assumes the bench calls send once a nibble, then once with enable low.
`timescale 1ns/10ps
`default_nettype none
module pld_mac_model (
    input  wire logic       mclk_i,
    input  wire logic       tx_clk_i,
    output var  logic [3:0] txd_o,
    output var  logic       tx_en_o
);
    // Waits that run out are counted for the bench's closing report
    int stalls = 0;
    initial begin
        txd_o = 4'h0;
        tx_en_o = 1'b0;
    end
    task automatic send(input logic [3:0] nib, input logic en);
        int k;
        for (k = 0; k < 100 && tx_clk_i !== 1'b0; k++) begin
            @(posedge mclk_i);
            #1;
        end
        stalls += int'(tx_clk_i !== 1'b0);
        // Released data bus flips so stale values never pass
        txd_o = en ? nib : ~txd_o;
        tx_en_o = en;
        for (k = 0; k < 100 && tx_clk_i !== 1'b1; k++) begin
            @(posedge mclk_i);
            #1;
        end
        stalls += int'(tx_clk_i !== 1'b1);
    endtask
endmodule
`default_nettype wire

/* bench/pld_top_test.sv */
// Bench of pld_top: 100M decode, 10M transmit and receive, jabber, link pulses.
// Assumes pld_mac_model as MAC; short timer parameters keep the run brief.
`timescale 1ns/10ps
`default_nettype none
module pld_top_test;
    localparam logic [79:0] CG = {5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17, 5'h16, 5'h13, 5'h12,
                                  5'h0F, 5'h0E, 5'h0B, 5'h0A, 5'h15, 5'h14, 5'h09, 5'h1E};
    localparam logic [9:0]  JK = {5'h18, 5'h11};
    logic        mclk_i = 1'b0, rst_b_i = 1'b0, byp, strb, rb, rv, line, sq, pl, kb, tq[$];
    logic [5:0]  adc, smp;
    logic [10:0] lf;
    logic [3:0]  rxd, rxd10, txd, d, q[$], q10[$];
    logic        sv, nv, dv, crs, er, lck, tck, tp, act, jab, tx_en, nv10, dv10, cer, pol, lok;
    int          failures = 0, checks = 0, seed = 32'h558F8BE2, ers = 0, cers = 0, k;
    pld_top #(.IDLE_TMO(16'h00C8), .JAB_LIM(24'h00012C), .NLP_PER(24'h0003E8),
              .LINK_LOSS(25'h00001F4)) i_pld_top (.mclk_i, .rst_b_i, .descr_bypass_i(byp),
        .adc_code_i(adc), .adc_strb_i(strb), .dsp_sample_o(smp), .dsp_sample_vld_o(sv),
        .rx100_bit_i(rb), .rx100_bit_vld_i(rv), .rxd_o(rxd), .rx_nib_vld_o(nv), .rx_dv_o(dv),
        .crs_o(crs), .rx_er_o(er), .descr_locked_o(lck), .tx_clk_o(tck), .txd_i(txd),
        .tx_en_i(tx_en), .tp_tx_o(tp), .tp_tx_act_o(act), .jabber_o(jab), .rx10_line_i(line),
        .rx10_squelch_i(sq), .rx10_rxd_o(rxd10), .rx10_nib_vld_o(nv10), .rx10_dv_o(dv10),
        .rx10_code_err_o(cer), .polarity_reversed_flag_o(pol), .link10_ok_o(lok));
    pld_mac_model i_pld_mac_model (.mclk_i, .tx_clk_i(tck), .txd_o(txd), .tx_en_o(tx_en));
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    task tick;
        @(posedge mclk_i);
        #1;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task test_done;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wt(ref logic s, input logic v, input int lim);
        for (k = 0; k < lim && s !== v; k++) tick;
        if (s !== v) begin
            failures++;
            $display("ERROR wait expected %b seen %b", v, s);
            test_done;
        end
    endtask
    task automatic sbit(input logic b);
        tick;
        rb = b;
        rv = 1'b1;
        tick;
        rv = 1'b0;
        // Noise on the unqualified bit must be ignored
        rb = 1'($random(seed));
    endtask
    // Scrambles with the bench's own copy of the key
    task automatic scb(input logic b);
        kb = lf[10] ^ lf[8];
        lf = {lf[9:0], kb};
        sbit(b ^ kb);
    endtask
    task automatic cg(input logic [4:0] c);
        for (int i = 4; i >= 0; i--) sbit(c[i]);
    endtask
    task automatic frame(input int n);
        q.push_back(4'h5);
        q.push_back(4'h5);
        cg(5'h18);
        cg(5'h11);
        repeat (n) begin
            d = 4'($random(seed));
            q.push_back(d);
            cg(CG[5 * int'(d) +: 5]);
        end
    endtask
    task automatic mbit(input logic b);
        line = ~b ^ pl;
        repeat (10) tick;
        line = b ^ pl;
        repeat (10) tick;
    endtask
    always @(posedge mclk_i) begin
        #1;
        ers += (er === 1'b1);
        cers += (cer === 1'b1);
        if (nv === 1'b1 && q.size() == 0) q.push_back(4'hX);
        if (nv10 === 1'b1 && q10.size() == 0) q10.push_back(4'hX);
        if (nv === 1'b1) chk("rxd", {4'h0, q.pop_front()}, {4'h0, rxd});
        if (nv10 === 1'b1) chk("rx10_rxd", {4'h0, q10.pop_front()}, {4'h0, rxd10});
    end
    always @(posedge act) if (tx_en === 1'b1 && tq.size() > 0) begin
        repeat (5) @(posedge mclk_i);
        while (tq.size() > 0) begin
            #1 chk("tx_first_half", {7'h00, ~tq[0]}, {7'h00, tp});
            repeat (10) @(posedge mclk_i);
            #1 chk("tx_second_half", {7'h00, tq.pop_front()}, {7'h00, tp});
            repeat (10) @(posedge mclk_i);
        end
    end
    initial begin
        #400000;
        failures++;
        $display("ERROR run_time expected end seen hang");
        test_done;
    end
    initial begin
        {byp, strb, rb, rv, line, sq, pl} = 7'h40;
        adc = 6'h00;
        repeat (3) @(posedge mclk_i);
        chk("reset_tx_clk", 8'h01, {7'h00, tck});
        chk("reset_outputs", 8'h00, {3'h0, dv, crs, act, jab, lok});
        #1 rst_b_i = 1'b1;
        adc = 6'($random(seed));
        tick;
        strb = 1'b1;
        tick;
        strb = 1'b0;
        wt(sv, 1'b1, 8);
        chk("dsp_sample", {2'h0, adc}, {2'h0, smp});
        repeat (4) cg(5'h1F);
        frame(6);
        chk("dv_crs_on", 8'h03, {6'h00, dv, crs});
        cg(5'h0D);
        cg(5'h07);
        repeat (4) tick;
        chk("dv_crs_end", 8'h00, {6'h00, dv, crs});
        ers = 0;
        frame(1);
        cg(5'h00);
        cg(5'h07);
        cg(5'h1F);
        cg(5'h1F);
        repeat (4) tick;
        chk("rx_er_count", 8'h02, 8'(ers));
        chk("dv_crs_idle", 8'h00, {6'h00, dv, crs});
        byp = 1'b0;
        lf = 11'($random(seed));
        for (int i = 10; i >= 0; i--) sbit(~lf[i]);
        wt(lck, 1'b1, 4);
        // Idle longer than the window only survives if it descrambles to ones
        repeat (150) scb(1'b1);
        chk("lock_held", 8'h01, {7'h00, lck});
        q.push_back(4'h5);
        q.push_back(4'h5);
        for (int i = 9; i >= 0; i--) scb(JK[i]);
        chk("dv_crs_locked", 8'h03, {6'h00, dv, crs});
        wt(lck, 1'b0, 260);
        chk("idle_window", 8'h01, {7'h00, k > 180});
        chk("dv_crs_abort", 8'h00, {6'h00, dv, crs});
        byp = 1'b1;
        wt(act, 1'b0, 30);
        wt(act, 1'b1, 1100);
        wt(act, 1'b0, 30);
        chk("link_pulse_len", 8'h01, {7'h00, k > 17 && k < 22});
        repeat (2) begin
            d = 4'($random(seed));
            for (int b = 0; b < 4; b++) tq.push_back(d[b]);
            i_pld_mac_model.send(d, 1'b1);
        end
        i_pld_mac_model.send(4'h0, 1'b0);
        for (k = 0; k < 300 && tq.size() > 0; k++) tick;
        chk("tx_bits_left", 8'h00, 8'(tq.size()));
        repeat (6) i_pld_mac_model.send(4'hF, 1'b1);
        chk("jabber_stop", 8'h02, {6'h00, jab, act});
        i_pld_mac_model.send(4'h0, 1'b0);
        repeat (3) tick;
        chk("jabber_clear", 8'h00, {7'h00, jab});
        line = 1'b1;
        repeat (20) tick;
        line = 1'b0;
        wt(lok, 1'b1, 10);
        wt(lok, 1'b0, 600);
        chk("link_loss", 8'h01, {7'h00, k > 450});
        // Third pass in normal wiring toggles the flag back
        for (int p = 0; p < 3; p++) begin
            pl = 1'(p % 2);
            line = pl;
            tick;
            sq = 1'b1;
            repeat (3) begin
                mbit(1'b1);
                mbit(1'b0);
            end
            mbit(1'b1);
            mbit(1'b1);
            repeat (2) begin
                d = 4'($random(seed));
                q10.push_back(d);
                for (int b = 0; b < 4; b++) mbit(d[b]);
            end
            chk("rx10_dv", 8'h01, {7'h00, dv10});
            line = 1'b0;
            sq = 1'b0;
            repeat (40) tick;
            chk("polarity_flag", {7'h00, pl}, {7'h00, pol});
        end
        sq = 1'b1;
        repeat (8) begin
            line = ~line;
            repeat (3) tick;
        end
        sq = 1'b0;
        chk("code_err", 8'h01, {7'h00, cers > 0});
        repeat (40) tick;
        chk("queues_empty", 8'h00, 8'(q.size() + q10.size()));
        chk("mac_stalls", 8'h00, 8'(i_pld_mac_model.stalls));
        test_done;
    end
endmodule
`default_nettype wire
